// ==== inc/pmt_map.svh ====
// Register offsets, field positions, reset values and divider limits.
`ifndef PMT_MAP_SVH
`define PMT_MAP_SVH

// ****************************************************************
// Register offsets (byte addresses).
// ****************************************************************
`define PMT_OFS_CTRL       4'h0
`define PMT_OFS_COUNT      4'h4
`define PMT_OFS_PERIOD     4'h8
`define PMT_OFS_EVENT      4'hC
`define PMT_OFS_W          4

// ****************************************************************
// Field positions.
// ****************************************************************
`define PMT_CKPS_LSB       0
`define PMT_CKPS_MSB       1
`define PMT_RUN_BIT        2
`define PMT_OUTPS_LSB      3
`define PMT_OUTPS_MSB      6
`define PMT_CTRL_MSB       6
`define PMT_EVT_FLAG_BIT   0
`define PMT_EVT_EN_BIT     1

// ****************************************************************
// Reset values.
// ****************************************************************
`define PMT_COUNT_RST      8'h00
`define PMT_PERIOD_RST     8'hFF
`define PMT_CTRL_RST       7'h00
`define PMT_POST_RST       4'h0
`define PMT_PRE_RST        6'h00
`define PMT_COUNT_STEP     8'h01
`define PMT_POST_STEP      4'h1
`define PMT_PRE_STEP       6'h01

// ****************************************************************
// Prescale select codes and terminal counts.
// ****************************************************************
`define PMT_SEL_DIV1       2'h0
`define PMT_SEL_DIV4       2'h1
`define PMT_SEL_DIV16      2'h2
`define PMT_SEL_DIV64      2'h3
`define PMT_LIM_DIV1       6'h00
`define PMT_LIM_DIV4       6'h03
`define PMT_LIM_DIV16      6'h0F
`define PMT_LIM_DIV64      6'h3F
`define PMT_PRE_MIN_W      6

`endif

// ==== inc/pmt_pkg.sv ====
// Types shared by the period match timer files.
package pmt_pkg;

   typedef enum logic [2:0] {
      PMT_REG_CTRL   = 3'h0,
      PMT_REG_COUNT  = 3'h1,
      PMT_REG_PERIOD = 3'h3,
      PMT_REG_EVENT  = 3'h2,
      PMT_REG_NONE   = 3'h6
   } pmt_reg_t;

   typedef enum logic [1:0] {
      PMT_RESP_OKAY   = 2'h0,
      PMT_RESP_SLVERR = 2'h2
   } pmt_resp_t;

   typedef logic [1:0] pmt_presel_t;

endpackage

// ==== verif/tb_top.sv ====
// Self-checking testbench for the period match timer.
`timescale 1ns/1ps
`default_nettype none
`include "pmt_map.svh"

module tb_top;
   localparam logic [11:0] A_CTRL = {8'h00, `PMT_OFS_CTRL};
   localparam logic [11:0] A_CNT  = {8'h00, `PMT_OFS_COUNT};
   localparam logic [11:0] A_PER  = {8'h00, `PMT_OFS_PERIOD};
   localparam logic [11:0] A_EVT  = {8'h00, `PMT_OFS_EVENT};
   localparam logic [11:0] A_BAD  = 12'h010;

   logic        aclk, aresetn, aclk_en, sleep_mode, awvalid, wvalid, bready;
   logic        arvalid, rready, awready, wready, bvalid, arready, rvalid;
   logic        match_out, ssp_shift_clk, match_irq_req;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   int          miscompares, checks, cyc, n_match;

   pmt_timer #(.ADDR_W(12), .PRE_W(6)) pmt_timer_i (
      .aclk(aclk), .aresetn(aresetn), .aclk_en(aclk_en),
      .sleep_mode(sleep_mode), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .match_out(match_out), .ssp_shift_clk(ssp_shift_clk),
      .match_irq_req(match_irq_req));

   initial aclk = 1'b0;
   always #5 aclk = ~aclk;

   // Free cycle count and unscaled match count, both seen as of each edge.
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (match_out === 1'b1) n_match <= n_match + 1;
   end

   // ****************************************************************
   // Reporting and bus tasks.
   // ****************************************************************
   task automatic wrap_up();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic timeout();
      miscompares++;
      $display("unexpected timeout at %0t: got %h expected %h", $time, 0, 1);
      wrap_up();
   endtask

   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                         input logic [1:0] er);
      int   n;
      logic done;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      done = 1'b0;
      n = 0;
      while (!done) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            bready <= 1'b0;
            done = 1'b1;
            chk({30'h0, bresp}, {30'h0, er});
         end
         n++;
         if (n > 100) timeout();
      end
   endtask

   task automatic axi_rd(input logic [11:0] a, output logic [31:0] d,
                         output logic [1:0] r);
      int   n;
      logic done;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      done = 1'b0;
      n = 0;
      while (!done) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            rready <= 1'b0;
            done = 1'b1;
            d = rdata;
            r = rresp;
         end
         n++;
         if (n > 100) timeout();
      end
   endtask

   task automatic reg_chk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0]  r;
      axi_rd(a, d, r);
      chk(d, exp);
      chk({30'h0, r}, 32'h0000_0000);
   endtask

   function automatic logic [31:0] ctl(input int n, run, ps);
      return (n << `PMT_OUTPS_LSB) | (run << `PMT_RUN_BIT) | ps;
   endfunction

   task automatic wait_match(output int at, output logic s);
      int n;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (n > 1000) timeout();
      end while (match_out !== 1'b1);
      at = cyc;
      s = ssp_shift_clk;
   endtask

   // ****************************************************************
   // Scenarios.
   // ****************************************************************
   task automatic t_reset();
      logic [31:0] d;
      logic [1:0]  r;
      reg_chk(A_CTRL, 32'h0000_0000);
      reg_chk(A_CNT, 32'h0000_0000);
      reg_chk(A_PER, 32'h0000_00FF);
      reg_chk(A_EVT, 32'h0000_0000);
      axi_rd(A_BAD, d, r);
      chk({r, d[29:0]}, 32'h8000_0000);
      axi_wr(A_BAD, 32'h0000_0012, 2'h2);
      $display("test reset done");
   endtask

   task automatic t_access();
      axi_wr(A_CNT, 32'h0000_0055, 2'h0);
      reg_chk(A_CNT, 32'h0000_0055);
      axi_wr(A_PER, 32'h0000_0033, 2'h0);
      reg_chk(A_PER, 32'h0000_0033);
      wstrb <= 4'hE;
      axi_wr(A_PER, 32'h0000_0077, 2'h0);
      wstrb <= 4'hF;
      reg_chk(A_PER, 32'h0000_0033);
      axi_wr(A_CTRL, ctl(9, 0, 3) | 32'h0000_0080, 2'h0);
      reg_chk(A_CNT, 32'h0000_0055);
      reg_chk(A_CTRL, ctl(9, 0, 3));
      $display("test access done");
   endtask

   task automatic t_period();
      int   t0, t1;
      logic s0, s1;
      for (int ps = 0; ps < 4; ps++) begin
         axi_wr(A_CTRL, ctl(0, 0, ps), 2'h0);
         axi_wr(A_PER, 32'h0000_0002, 2'h0);
         axi_wr(A_CNT, 32'h0000_0000, 2'h0);
         axi_wr(A_CTRL, ctl(0, 1, ps), 2'h0);
         wait_match(t0, s0);
         wait_match(t1, s1);
         chk(t1 - t0, 3 * (1 << (2 * ps)));
         chk({31'h0, s1}, {31'h0, ~s0});
      end
      $display("test period done");
   endtask

   task automatic t_post();
      int ns[3] = '{0, 1, 15};
      int m0, n, hi;
      axi_wr(A_PER, 32'h0000_0003, 2'h0);
      foreach (ns[i]) begin
         axi_wr(A_CTRL, ctl(ns[i], 0, 0), 2'h0);
         axi_wr(A_CNT, 32'h0000_0000, 2'h0);
         axi_wr(A_EVT, 32'h0000_0003, 2'h0);
         m0 = n_match;
         axi_wr(A_CTRL, ctl(ns[i], 1, 0), 2'h0);
         n = 0;
         while (match_irq_req !== 1'b1) begin
            @(posedge aclk);
            n++;
            if (n > 300) timeout();
         end
         @(posedge aclk);
         chk(n_match - m0, ns[i] + 1);
      end
      axi_wr(A_CTRL, ctl(0, 0, 0), 2'h0);
      axi_wr(A_EVT, 32'h0000_0001, 2'h0);
      axi_wr(A_CTRL, ctl(0, 1, 0), 2'h0);
      hi = 0;
      repeat (30) begin
         @(posedge aclk);
         if (match_irq_req !== 1'b0) hi++;
      end
      chk(hi, 0);
      axi_wr(A_CTRL, ctl(0, 0, 0), 2'h0);
      reg_chk(A_EVT, 32'h0000_0001);
      $display("test postscale done");
   endtask

   task automatic t_hold();
      logic [31:0] c0, c1;
      logic [1:0]  r;
      int          m0;
      axi_wr(A_PER, 32'h0000_00FF, 2'h0);
      axi_wr(A_CTRL, ctl(0, 1, 0), 2'h0);
      @(posedge aclk);
      sleep_mode <= 1'b1;
      axi_rd(A_CNT, c0, r);
      repeat (20) @(posedge aclk);
      reg_chk(A_CNT, c0);
      reg_chk(A_PER, 32'h0000_00FF);
      @(posedge aclk);
      sleep_mode <= 1'b0;
      repeat (5) @(posedge aclk);
      axi_rd(A_CNT, c1, r);
      chk({31'h0, c1 !== c0}, 32'h0000_0001);
      axi_wr(A_CTRL, ctl(0, 0, 0), 2'h0);
      axi_wr(A_CNT, 32'h0000_0000, 2'h0);
      axi_wr(A_CTRL, ctl(0, 1, 0), 2'h0);
      aclk_en <= 1'b0;
      repeat (40) @(posedge aclk);
      aclk_en <= 1'b1;
      axi_rd(A_CNT, c1, r);
      chk({31'h0, c1 < 32'h0000_000A}, 32'h0000_0001);
      axi_wr(A_CTRL, ctl(0, 0, 0), 2'h0);
      axi_rd(A_CNT, c0, r);
      m0 = n_match;
      repeat (300) @(posedge aclk);
      reg_chk(A_CNT, c0);
      chk(n_match - m0, 0);
      $display("test hold done");
   endtask

   initial begin
      aresetn = 1'b0;
      aclk_en = 1'b1;
      sleep_mode = 1'b0;
      awvalid = 1'b0;
      wvalid = 1'b0;
      bready = 1'b0;
      arvalid = 1'b0;
      rready = 1'b0;
      awaddr = 12'h000;
      araddr = 12'h000;
      wdata = 32'h0000_0000;
      wstrb = 4'hF;
      miscompares = 0;
      checks = 0;
      cyc = 0;
      n_match = 0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_access();
      t_period();
      t_post();
      t_hold();
      wrap_up();
   end
endmodule // tb_top
`default_nettype wire

// ==== verilog/pmt_prescaler.sv ====
// Input prescaler of the period match timer.
`timescale 1ns/1ps
`default_nettype none
`include "pmt_map.svh"

module pmt_prescaler #(
   parameter int PRE_W = 6
) (
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   input  wire logic                 aclk_en,
   input  wire logic                 run,
   input  wire logic                 clear,
   input  wire pmt_pkg::pmt_presel_t sel,
   output logic                      tick
);

   logic [PRE_W-1:0] pre_reg;
   logic [PRE_W-1:0] lim;

   generate
      if (PRE_W < `PMT_PRE_MIN_W) begin : g_chk
         $error("pmt_prescaler: PRE_W too small for divide by 64");
      end
   endgenerate

   // Maps the select code onto the last count before a tick.
   always_comb begin
      case (sel)
         `PMT_SEL_DIV1:  lim = PRE_W'(`PMT_LIM_DIV1);
         `PMT_SEL_DIV4:  lim = PRE_W'(`PMT_LIM_DIV4);
         `PMT_SEL_DIV16: lim = PRE_W'(`PMT_LIM_DIV16);
         default:        lim = PRE_W'(`PMT_LIM_DIV64);
      endcase
   end

   // A clear suppresses the tick so that a control or count write never steps the count.
   assign tick = run && !clear && (pre_reg >= lim);

   // The count is internal and never visible to software.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pre_reg <= PRE_W'(`PMT_PRE_RST);
      end else if (aclk_en) begin
         if (clear || tick) begin
            pre_reg <= PRE_W'(`PMT_PRE_RST);
         end else if (run) begin
            pre_reg <= pre_reg + PRE_W'(`PMT_PRE_STEP);
         end
      end
   end

   // ****************************************************************
   // Checks.
   // ****************************************************************
   a_pre_clear: assert property (@(posedge aclk)
      disable iff (!aresetn || !aclk_en)
      (aclk_en && clear) |=> pre_reg == PRE_W'(`PMT_PRE_RST))
      else $error("prescaler not cleared");

   a_pre_div: assert property (@(posedge aclk)
      disable iff (!aresetn || !aclk_en)
      (aclk_en && tick && sel == `PMT_SEL_DIV64)
      |-> pre_reg == PRE_W'(`PMT_LIM_DIV64) ##1 !tick)
      else $error("divide by 64 ticked early");

endmodule // pmt_prescaler
`default_nettype wire

// ==== verilog/pmt_timer.sv ====
// Period match timer with AXI4-Lite register access.
// How it works
// - The timer runs only on the instruction clock, no external clock.
// - The count starts at zero and steps once per prescaled tick.
// - Prescale select picks divide by 1, 4, 16 or 64; code 11 is 64.
// - Count equal to period raises the match output.
// - A match reloads zero next cycle and steps the postscaler.
// - Software reads and writes count and period at any time.
// - Reset clears the count and sets the period to all ones.
// - Count writes, control writes and resets clear both scalers.
// - A control write leaves the count unchanged.
// - A four bit postscaler counts matches and latches the event flag.
// - The flag requests an interrupt only when its enable is set.
// - Postscale field n gives one flag per n+1 matches.
// - The unscaled match goes to the capture/compare/PWM unit.
// - The unscaled match offers a shift clock to the serial port.
// - In sleep the timer stops; count and period keep their values.
`timescale 1ns/1ps
`default_nettype none
`include "pmt_map.svh"

module pmt_timer #(
   parameter int ADDR_W = 12,
   parameter int PRE_W  = 6
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic              aclk_en,
   input  wire logic              sleep_mode,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   output logic                   match_out,
   output logic                   ssp_shift_clk,
   output logic                   match_irq_req
);

   generate
      if (ADDR_W < `PMT_OFS_W) begin : g_chk
         $error("pmt_timer: ADDR_W too small for the register map");
      end
   endgenerate

   // ****************************************************************
   // Address decode.
   // ****************************************************************
   function automatic pmt_pkg::pmt_reg_t reg_decode(
      input logic [ADDR_W-1:0] a
   );
      logic [ADDR_W-1:0] hi;
      hi = a >> `PMT_OFS_W;
      if (hi != '0) begin
         return pmt_pkg::PMT_REG_NONE;
      end
      case (a[`PMT_OFS_W-1:0])
         `PMT_OFS_CTRL:   return pmt_pkg::PMT_REG_CTRL;
         `PMT_OFS_COUNT:  return pmt_pkg::PMT_REG_COUNT;
         `PMT_OFS_PERIOD: return pmt_pkg::PMT_REG_PERIOD;
         `PMT_OFS_EVENT:  return pmt_pkg::PMT_REG_EVENT;
         default:         return pmt_pkg::PMT_REG_NONE;
      endcase
   endfunction

   // ****************************************************************
   // Registers and strobes.
   // ****************************************************************
   logic [`PMT_CTRL_MSB:0] ctrl_reg;
   logic [7:0]             count_reg;
   logic [7:0]             period_reg;
   logic [3:0]             post_reg;
   logic                   flag_reg;
   logic                   ie_reg;
   logic                   shift_reg;
   logic                   irq_reg;
   logic                   match_reg;
   logic [ADDR_W-1:0]      aw_addr_reg;
   logic [7:0]             wdata_reg;
   logic                   wstrb_reg;
   logic                   awready_reg;
   logic                   wready_reg;
   logic                   bvalid_reg;
   logic [1:0]             bresp_reg;
   logic                   arready_reg;
   logic                   rvalid_reg;
   logic [31:0]            rdata_reg;
   logic [1:0]             rresp_reg;

   pmt_pkg::pmt_reg_t      wr_sel;
   logic                   wr_go;
   logic                   wr_ctrl;
   logic                   wr_count;
   logic                   wr_period;
   logic                   wr_event;
   logic                   run_eff;
   logic                   tick;
   logic                   hit;
   logic                   post_done;
   logic [3:0]             post_sel;

   assign wr_go     = !awready_reg && !wready_reg && !bvalid_reg;
   assign wr_sel    = reg_decode(aw_addr_reg);
   assign wr_ctrl   = wr_go && wstrb_reg && wr_sel == pmt_pkg::PMT_REG_CTRL;
   assign wr_count  = wr_go && wstrb_reg && wr_sel == pmt_pkg::PMT_REG_COUNT;
   assign wr_period = wr_go && wstrb_reg
                      && wr_sel == pmt_pkg::PMT_REG_PERIOD;
   assign wr_event  = wr_go && wstrb_reg && wr_sel == pmt_pkg::PMT_REG_EVENT;

   // Sleep stops the count without touching any register.
   assign run_eff   = ctrl_reg[`PMT_RUN_BIT] && !sleep_mode;
   assign post_sel  = ctrl_reg[`PMT_OUTPS_MSB:`PMT_OUTPS_LSB];
   assign hit       = tick && (count_reg == period_reg);
   assign post_done = post_reg == post_sel;

   // ****************************************************************
   // Write channels.
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_reg <= 1'b1;
         wready_reg  <= 1'b1;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= pmt_pkg::PMT_RESP_OKAY;
         aw_addr_reg <= '0;
         wdata_reg   <= '0;
         wstrb_reg   <= 1'b0;
      end else if (aclk_en) begin
         if (awvalid && awready_reg) begin
            aw_addr_reg <= awaddr;
            awready_reg <= 1'b0;
         end
         if (wvalid && wready_reg) begin
            wdata_reg  <= wdata[7:0];
            wstrb_reg  <= wstrb[0];
            wready_reg <= 1'b0;
         end
         if (wr_go) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= (wr_sel == pmt_pkg::PMT_REG_NONE) ?
                          pmt_pkg::PMT_RESP_SLVERR : pmt_pkg::PMT_RESP_OKAY;
         end else if (bvalid_reg && bready) begin
            bvalid_reg  <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // Read channels.
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_reg <= 1'b1;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= '0;
         rresp_reg   <= pmt_pkg::PMT_RESP_OKAY;
      end else if (aclk_en) begin
         if (arvalid && arready_reg) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            rresp_reg   <= pmt_pkg::PMT_RESP_OKAY;
            case (reg_decode(araddr))
               pmt_pkg::PMT_REG_CTRL:   rdata_reg <= {25'h0, ctrl_reg};
               pmt_pkg::PMT_REG_COUNT:  rdata_reg <= {24'h0, count_reg};
               pmt_pkg::PMT_REG_PERIOD: rdata_reg <= {24'h0, period_reg};
               pmt_pkg::PMT_REG_EVENT:  rdata_reg <= {30'h0, ie_reg, flag_reg};
               default: begin
                  rdata_reg <= '0;
                  rresp_reg <= pmt_pkg::PMT_RESP_SLVERR;
               end
            endcase
         end else if (rvalid_reg && rready) begin
            rvalid_reg  <= 1'b0;
            arready_reg <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // Control, period and event enable.
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg   <= `PMT_CTRL_RST;
         period_reg <= `PMT_PERIOD_RST;
         ie_reg     <= 1'b0;
      end else if (aclk_en) begin
         if (wr_ctrl) begin
            ctrl_reg <= wdata_reg[`PMT_CTRL_MSB:0];
         end
         if (wr_period) begin
            period_reg <= wdata_reg;
         end
         if (wr_event) begin
            ie_reg <= wdata_reg[`PMT_EVT_EN_BIT];
         end
      end
   end

   // ****************************************************************
   // Prescaler and count.
   // ****************************************************************
   pmt_prescaler #(
      .PRE_W (PRE_W)
   ) u_pre (
      .aclk    (aclk),
      .aresetn (aresetn),
      .aclk_en (aclk_en),
      .run     (run_eff),
      .clear   (wr_ctrl || wr_count),
      .sel     (ctrl_reg[`PMT_CKPS_MSB:`PMT_CKPS_LSB]),
      .tick    (tick)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_reg <= `PMT_COUNT_RST;
      end else if (aclk_en) begin
         if (wr_count) begin
            count_reg <= wdata_reg;
         end else if (hit) begin
            count_reg <= `PMT_COUNT_RST;
         end else if (tick) begin
            count_reg <= count_reg + `PMT_COUNT_STEP;
         end
      end
   end

   // ****************************************************************
   // Postscaler, event flag and match outputs.
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         post_reg <= `PMT_POST_RST;
      end else if (aclk_en) begin
         if (wr_ctrl || wr_count) begin
            post_reg <= `PMT_POST_RST;
         end else if (hit) begin
            post_reg <= post_done ? `PMT_POST_RST
                                  : post_reg + `PMT_POST_STEP;
         end
      end
   end

   // A new event wins over a clear in the same cycle.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag_reg <= 1'b0;
      end else if (aclk_en) begin
         if (hit && post_done) begin
            flag_reg <= 1'b1;
         end else if (wr_event && wdata_reg[`PMT_EVT_FLAG_BIT]) begin
            flag_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_reg   <= 1'b0;
         match_reg <= 1'b0;
         shift_reg <= 1'b0;
      end else if (aclk_en) begin
         irq_reg   <= flag_reg && ie_reg;
         match_reg <= hit;
         if (hit) begin
            shift_reg <= !shift_reg;
         end
      end
   end

   assign awready       = awready_reg;
   assign wready        = wready_reg;
   assign bvalid        = bvalid_reg;
   assign bresp         = bresp_reg;
   assign arready       = arready_reg;
   assign rvalid        = rvalid_reg;
   assign rdata         = rdata_reg;
   assign rresp         = rresp_reg;
   assign match_out     = match_reg;
   assign ssp_shift_clk = shift_reg;
   assign match_irq_req = irq_reg;

   // ****************************************************************
   // Checks.
   // ****************************************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn || !aclk_en);

   a_count_step: assert property (
      (aclk_en && tick && !hit) |=> count_reg == $past(count_reg) + 8'h01)
      else $error("count did not step by one");
   a_match_wrap: assert property (
      (aclk_en && hit && !wr_count) |=> count_reg == 8'h00 && match_out)
      else $error("match did not reload zero");
   a_match_only: assert property (
      match_out |-> $past(count_reg) == $past(period_reg))
      else $error("match without equal count");
   a_ctrl_keep: assert property (
      (wr_ctrl && !wr_count) |=> $stable(count_reg) && post_reg == 4'h0)
      else $error("control write disturbed the count");
   a_stop_hold: assert property (
      (!run_eff && !wr_count) |=> $stable(count_reg) && !match_out)
      else $error("stopped timer moved");
   a_sleep_keep: assert property (
      (sleep_mode && !wr_count && !wr_period)
      |=> $stable(count_reg) && $stable(period_reg))
      else $error("sleep changed count or period");
   a_flag_set: assert property (
      (aclk_en && hit && post_done) |=> flag_reg ##1 irq_reg == $past(ie_reg))
      else $error("event flag not latched");
   a_irq_gate: assert property (
      irq_reg |-> $past(ie_reg) && $past(flag_reg))
      else $error("interrupt request without enable");
   a_reset_vals: assert property (
      $rose(aresetn) |-> count_reg == 8'h00 && period_reg == 8'hFF)
      else $error("reset values wrong");
   a_bresp_hold: assert property (
      (bvalid && !bready) |=> bvalid && $stable(bresp))
      else $error("write response dropped");

   c_match:  cover property (hit ##1 match_out);
   c_flag:   cover property (hit && post_done && post_sel == 4'hF);
   c_wr_cnt: cover property (wr_count ##1 bvalid);
   c_irq:    cover property ($rose(match_irq_req));

endmodule // pmt_timer
`default_nettype wire
